// ---- bfds_defs.vh ----
// register offsets, field positions, reset values and timing constants of the status bank
`ifndef BFDS_DEFS_VH
`define BFDS_DEFS_VH

// ----------------------------------------------------------------------
// serial register addresses (7-bit)
// ----------------------------------------------------------------------
`define BFDS_ADDR_W 7
`define BFDS_ADDR_FAULT 7'h52
`define BFDS_ADDR_DELAY1 7'h53
`define BFDS_ADDR_DELAY2 7'h54
`define BFDS_ADDR_DELAY3 7'h55

// ----------------------------------------------------------------------
// fault register bit positions
// ----------------------------------------------------------------------
`define BFDS_BIT_SENSE_OC 14
`define BFDS_BIT_INT_BRAKE 13
`define BFDS_BIT_BRIDGE_BRAKE 12
`define BFDS_BIT_LOW3_BRK 10
`define BFDS_BIT_LOW2_BRK 9
`define BFDS_BIT_LOW1_BRK 8
`define BFDS_BIT_LOW3 5
`define BFDS_BIT_HIGH3 4
`define BFDS_BIT_LOW2 3
`define BFDS_BIT_HIGH2 2
`define BFDS_BIT_LOW1 1
`define BFDS_BIT_HIGH1 0

// ----------------------------------------------------------------------
// delay register fields
// ----------------------------------------------------------------------
`define BFDS_CODE_W 6
`define BFDS_ON_LSB 0
`define BFDS_OFF_LSB 8

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define BFDS_FAULT_RESET 16'h0000
`define BFDS_DELAY_RESET 16'h0000
`define BFDS_FLAG_COUNT 12
`define BFDS_DELAY_STEP_PS 53300

`endif

// ---- bfds_host.sv ----
// host model issuing register reads
`timescale 1ns/1ns
module bfds_host (
	// clock
	input wire clock,
	// read port
	output reg rd_strobe,
	output reg [6:0] rd_addr,
	input wire [15:0] rd_data,
	input wire rd_valid,
	input wire rd_hit
);
	reg [15:0] fault_log; // a fault read clears flags, so the host keeps them
	initial begin
		rd_strobe = 1'b0;
		rd_addr = 7'h00;
		fault_log = 16'h0000;
	end
	// one strobe cycle, answer settled by the following falling edge
	task rd(input [6:0] a, output [15:0] d, output h);
		begin
			@(negedge clock);
			rd_strobe = 1'b1;
			rd_addr = a;
			@(negedge clock);
			rd_strobe = 1'b0;
			rd_addr = ~a; // no stale address once released
			d = rd_data;
			h = rd_hit & rd_valid;
			if (a == 7'h52) fault_log = fault_log | d;
		end
	endtask
endmodule // bfds_host

// ---- bfds_status_bank.v ----
// fault flag and effective delay status registers read over the serial interface
`timescale 1ns/1ns
`include "bfds_defs.vh"

module bfds_status_bank #(
	parameter CODE_W = `BFDS_CODE_W
) (
	// clock and reset
	input wire clock,
	input wire rst,
	input wire soft_rst,
	// asynchronous fault condition levels, high while present
	input wire sense_overcurrent_in,
	input wire internal_supply_brake_in,
	input wire bridge_supply_brake_in,
	input wire [2:0] low_overvoltage_braking_in,
	input wire [2:0] low_overvoltage_in,
	input wire [2:0] high_overvoltage_in,
	// measured delay codes from the delay measurement logic, same clock
	input wire [2:0] delay_update,
	input wire [3*CODE_W-1:0] on_delay_code_in,
	input wire [3*CODE_W-1:0] off_delay_code_in,
	// register read port from the serial interface core
	input wire rd_strobe,
	input wire [`BFDS_ADDR_W-1:0] rd_addr,
	output reg [15:0] rd_data,
	output reg rd_valid,
	output reg rd_hit
);

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------

	// place both 6-bit codes, reserved bits 15:14 and 7:6 forced to zero
	function [15:0] pack_delay;
		input [CODE_W-1:0] on_code;
		input [CODE_W-1:0] off_code;
		begin
			pack_delay = 16'h0000;
			pack_delay[`BFDS_ON_LSB +: CODE_W] = on_code;
			pack_delay[`BFDS_OFF_LSB +: CODE_W] = off_code;
		end
	endfunction

	// spread the compact flag vector to its register positions
	function [15:0] pack_fault;
		input [`BFDS_FLAG_COUNT-1:0] f;
		begin
			pack_fault = `BFDS_FAULT_RESET;
			pack_fault[`BFDS_BIT_SENSE_OC] = f[11];
			pack_fault[`BFDS_BIT_INT_BRAKE] = f[10];
			pack_fault[`BFDS_BIT_BRIDGE_BRAKE] = f[9];
			pack_fault[`BFDS_BIT_LOW3_BRK] = f[8];
			pack_fault[`BFDS_BIT_LOW2_BRK] = f[7];
			pack_fault[`BFDS_BIT_LOW1_BRK] = f[6];
			pack_fault[`BFDS_BIT_LOW3] = f[5];
			pack_fault[`BFDS_BIT_HIGH3] = f[4];
			pack_fault[`BFDS_BIT_LOW2] = f[3];
			pack_fault[`BFDS_BIT_HIGH2] = f[2];
			pack_fault[`BFDS_BIT_LOW1] = f[1];
			pack_fault[`BFDS_BIT_HIGH1] = f[0];
		end
	endfunction

	// ----------------------------------------------------------------------
	// fault condition synchronisation
	// ----------------------------------------------------------------------

	wire [`BFDS_FLAG_COUNT-1:0] raw_faults;
	wire [`BFDS_FLAG_COUNT-1:0] fault_seen;

	// compact order: [11] overcurrent .. [0] high side 1
	assign raw_faults = {
		sense_overcurrent_in,
		internal_supply_brake_in,
		bridge_supply_brake_in,
		low_overvoltage_braking_in[2],
		low_overvoltage_braking_in[1],
		low_overvoltage_braking_in[0],
		low_overvoltage_in[2],
		high_overvoltage_in[2],
		low_overvoltage_in[1],
		high_overvoltage_in[1],
		low_overvoltage_in[0],
		high_overvoltage_in[0]
	};

	// fault levels come from the analogue comparators, so they cross in here
	bfds_sync #(
		.WIDTH(`BFDS_FLAG_COUNT)
	) u_fault_sync (
		.clock(clock),
		.rst(rst),
		.async_in(raw_faults),
		.sync_out(fault_seen)
	);

	// ----------------------------------------------------------------------
	// sticky fault flags
	// ----------------------------------------------------------------------

	reg [`BFDS_FLAG_COUNT-1:0] fault_flags;
	reg [`BFDS_FLAG_COUNT-1:0] next_fault_flags;
	wire fault_read;

	assign fault_read = rd_strobe && (rd_addr == `BFDS_ADDR_FAULT);

	// a read clears what it returns, but a condition seen in the same cycle
	// sets the flag again so no event slips between read and clear
	always @* begin
		next_fault_flags = fault_flags;
		if (fault_read) begin
			next_fault_flags = {`BFDS_FLAG_COUNT{1'b0}};
		end
		next_fault_flags = next_fault_flags | fault_seen;
	end

	// restart is not a reset here: flags clear only on power-on reset, soft reset or a fault register read
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			fault_flags <= {`BFDS_FLAG_COUNT{1'b0}};
		end else if (soft_rst) begin
			fault_flags <= {`BFDS_FLAG_COUNT{1'b0}};
		end else begin
			fault_flags <= next_fault_flags;
		end
	end

	// ----------------------------------------------------------------------
	// effective delay codes
	// ----------------------------------------------------------------------

	reg [CODE_W-1:0] on_code [0:2];
	reg [CODE_W-1:0] off_code [0:2];
	integer i;

	// each bridge keeps its last measurement until the next update strobe or soft reset;
	// a restart leaves the codes alone
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 3; i = i + 1) begin
				on_code[i] <= {CODE_W{1'b0}};
				off_code[i] <= {CODE_W{1'b0}};
			end
		end else begin
			for (i = 0; i < 3; i = i + 1) begin
				if (soft_rst) begin
					on_code[i] <= {CODE_W{1'b0}};
					off_code[i] <= {CODE_W{1'b0}};
				end else if (delay_update[i]) begin
					on_code[i] <= on_delay_code_in[i*CODE_W +: CODE_W];
					off_code[i] <= off_delay_code_in[i*CODE_W +: CODE_W];
				end
			end
		end
	end

	// ----------------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------------

	reg [15:0] next_rd_data;
	reg next_rd_hit;

	// the fault word shows the flags before this read's clear takes effect;
	// unmapped addresses answer zero with the hit flag low
	always @* begin
		next_rd_data = 16'h0000;
		next_rd_hit = 1'b1;
		case (rd_addr)
			`BFDS_ADDR_FAULT: begin
				next_rd_data = pack_fault(fault_flags);
			end
			`BFDS_ADDR_DELAY1: begin
				next_rd_data = pack_delay(on_code[0], off_code[0]);
			end
			`BFDS_ADDR_DELAY2: begin
				next_rd_data = pack_delay(on_code[1], off_code[1]);
			end
			`BFDS_ADDR_DELAY3: begin
				next_rd_data = pack_delay(on_code[2], off_code[2]);
			end
			default: begin
				next_rd_hit = 1'b0;
			end
		endcase
	end

	// answer one cycle after the strobe; data holds until the next read
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
			rd_hit <= 1'b0;
		end else begin
			rd_valid <= rd_strobe;
			if (rd_strobe) begin
				rd_data <= next_rd_data;
				rd_hit <= next_rd_hit;
			end
		end
	end

endmodule // bfds_status_bank

// ---- bfds_sva.sv ----
// assertion checker for the status bank read port
`timescale 1ns/1ns
module bfds_sva #(
	parameter CODE_W = 6
) (
	// clock and resets
	input wire clock,
	input wire rst,
	input wire soft_rst,
	// watched inputs
	input wire sense_overcurrent_in,
	input wire [2:0] high_overvoltage_in,
	input wire [2:0] delay_update,
	input wire [3*CODE_W-1:0] on_delay_code_in,
	input wire [3*CODE_W-1:0] off_delay_code_in,
	// read port
	input wire rd_strobe,
	input wire [6:0] rd_addr,
	input wire [15:0] rd_data,
	input wire rd_valid,
	input wire rd_hit
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_valid_one_pulse: assert property (rd_valid == $past(rd_strobe)) else $error("bad answer");
	a_unmapped_zero: assert property (rd_valid && !rd_hit |-> rd_data == 16'h0)
		else $error("unmapped data");
	a_hit_decode: assert property (rd_strobe |=> rd_hit == ($past(rd_addr) inside {[7'h52:7'h55]}))
		else $error("bad hit");
	a_fault_reserved: assert property (rd_valid && $past(rd_addr) == 7'h52 |->
		!rd_data[15] && !rd_data[11] && rd_data[7:6] == 2'h0) else $error("fault reserved");
	a_delay_reserved: assert property (rd_valid && $past(rd_addr) inside {[7'h53:7'h55]}
		|-> rd_data[15:14] == 2'h0 && rd_data[7:6] == 2'h0) else $error("delay reserved");
	a_overcurrent_seen: assert property ((sense_overcurrent_in && !soft_rst)[*5] ##0
		(rd_strobe && rd_addr == 7'h52) |=> rd_data[14]) else $error("no overcurrent");
	a_high1_seen: assert property ((high_overvoltage_in[0] && !soft_rst)[*5] ##0
		(rd_strobe && rd_addr == 7'h52) |=> rd_data[0]) else $error("no high1 flag");
	a_bridge1_load: assert property (delay_update[0] && !soft_rst ##1
		(rd_strobe && rd_addr == 7'h53) |=> rd_data[13:0] ==
		{$past(off_delay_code_in[5:0], 2), 2'h0, $past(on_delay_code_in[5:0], 2)})
		else $error("bridge1 code");
	a_soft_zero: assert property (soft_rst ##1 (rd_strobe && rd_addr == 7'h53)
		|=> rd_data == 16'h0) else $error("soft reset kept");
endmodule // bfds_sva

// ---- bfds_sync.v ----
// two-flop synchroniser for a group of asynchronous fault levels
`timescale 1ns/1ns

module bfds_sync #(
	parameter WIDTH = 12
) (
	// clock and reset
	input wire clock,
	input wire rst,
	// asynchronous levels in, synchronised levels out
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta;

	// first stage is read only by the second stage
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			meta <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule // bfds_sync

// ---- test_bfds_status_bank.sv ----
// self-checking testbench of the status bank
`timescale 1ns/1ns
module test_bfds_status_bank;
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg soft_rst = 1'b0;
	reg [11:0] f = 12'h000; // oc, int, bridge, braking low 3..1, low 3..1, high 3..1
	reg [2:0] upd = 3'h0;
	reg [17:0] on_c = 18'h0;
	reg [17:0] off_c = 18'h0;
	wire rd_strobe, rd_valid, rd_hit;
	wire [6:0] rd_addr;
	wire [15:0] rd_data;
	reg [15:0] d;
	reg h;
	integer err_total = 0, checks = 0, k;
	int pos[12] = '{14, 13, 12, 10, 9, 8, 5, 3, 1, 4, 2, 0};
	initial forever #2 clock = ~clock;
	bfds_status_bank i_bfds_status_bank (.clock(clock), .rst(rst), .soft_rst(soft_rst),
		.sense_overcurrent_in(f[11]), .internal_supply_brake_in(f[10]),
		.bridge_supply_brake_in(f[9]), .low_overvoltage_braking_in(f[8:6]),
		.low_overvoltage_in(f[5:3]), .high_overvoltage_in(f[2:0]), .delay_update(upd),
		.on_delay_code_in(on_c), .off_delay_code_in(off_c), .rd_strobe(rd_strobe),
		.rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));
	bfds_host i_bfds_host (.clock(clock), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));
	task chk(input [15:0] got, input [15:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", checks, err_total);
			if (err_total == 0 && checks > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	// reset values of all four registers, then an unmapped address
	task t_reset;
		for (k = 0; k < 5; k = k + 1) begin
			i_bfds_host.rd(7'(7'h52 + k), d, h);
			chk(d, 16'h0000);
			chk({15'h0, h}, {15'h0, k < 4});
		end
	endtask
	// each condition alone sets only its flag; the read clears it
	task t_faults;
		for (k = 0; k < 12; k = k + 1) begin
			f = 12'h800 >> k;
			repeat (4) @(negedge clock);
			f = 12'h000;
			repeat (4) @(negedge clock);
			i_bfds_host.rd(7'h52, d, h);
			chk(d, 16'h1 << pos[k]);
			i_bfds_host.rd(7'h52, d, h);
			chk(d, 16'h0000);
		end
	endtask
	// persisting conditions survive reads; soft reset clears
	task t_persist;
		begin
			f = 12'h801;
			repeat (5) @(negedge clock);
			i_bfds_host.rd(7'h52, d, h);
			chk(d, 16'h4001);
			i_bfds_host.rd(7'h52, d, h);
			chk(d, 16'h4001);
			f = 12'h000;
			repeat (4) @(negedge clock);
			soft_rst = 1'b1;
			i_bfds_host.rd(7'h52, d, h);
			soft_rst = 1'b0;
			chk(d, 16'h0000);
		end
	endtask
	// per-bridge code loading with boundary codes, then soft reset
	task t_delays;
		begin
			on_c = {6'h15, 6'h3f, 6'h01};
			off_c = {6'h2a, 6'h00, 6'h3e};
			upd = 3'h7;
			i_bfds_host.rd(7'h53, d, h);
			upd = 3'h2;
			on_c = 18'h0;
			off_c = {6'h00, 6'h3f, 6'h00};
			chk(d, 16'h3e01);
			@(negedge clock);
			upd = 3'h0;
			i_bfds_host.rd(7'h53, d, h);
			chk(d, 16'h3e01);
			i_bfds_host.rd(7'h54, d, h);
			chk(d, 16'h3f00);
			i_bfds_host.rd(7'h55, d, h);
			chk(d, 16'h2a15);
			soft_rst = 1'b1;
			upd = 3'h7; // a load in a soft reset cycle must lose
			on_c = 18'h3ffff;
			for (k = 0; k < 3; k = k + 1) begin
				i_bfds_host.rd(7'(7'h53 + k), d, h);
				chk(d, 16'h0000);
			end
			soft_rst = 1'b0;
			upd = 3'h0;
		end
	endtask
	// power-on reset in mid-run clears set flags and loaded codes
	task t_power;
		begin
			f = 12'hfff;
			upd = 3'h7;
			on_c = 18'h3ffff;
			repeat (5) @(negedge clock);
			f = 12'h000;
			upd = 3'h0;
			repeat (4) @(negedge clock);
			rst = 1'b1;
			repeat (2) @(negedge clock);
			rst = 1'b0;
			i_bfds_host.rd(7'h52, d, h);
			chk(d, 16'h0000);
			i_bfds_host.rd(7'h53, d, h);
			chk(d, 16'h0000);
		end
	endtask
	initial begin
		repeat (6) @(negedge clock);
		rst = 1'b0;
		t_reset;
		t_faults;
		chk(i_bfds_host.fault_log, 16'h773f);
		t_persist;
		t_delays;
		t_power;
		give_verdict;
	end
	// watchdog well beyond the few hundred cycles the run needs
	initial begin
		#20000;
		err_total = err_total + 1;
		give_verdict;
	end
endmodule // test_bfds_status_bank
bind bfds_status_bank bfds_sva #(.CODE_W(CODE_W)) i_bfds_sva (.clock(clock), .rst(rst),
	.soft_rst(soft_rst), .sense_overcurrent_in(sense_overcurrent_in),
	.high_overvoltage_in(high_overvoltage_in), .delay_update(delay_update),
	.on_delay_code_in(on_delay_code_in), .off_delay_code_in(off_delay_code_in),
	.rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
	.rd_hit(rd_hit));
